// >>> rtl/sfe_pkg.sv
/*
  package for the serial flash erase and read-modify-write command sequencer (host end).
  assumes one system clock and a flash that answers on its serial output pin.
*/
package sfe_pkg;
  // ==========================================================================
  // register port
  localparam int          REG_ADDR_W      = 8;
  localparam int          REG_DATA_W      = 32;
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_ADDR        = 8'h04;
  localparam logic [7:0]  REG_COUNT       = 8'h08;
  localparam logic [7:0]  REG_DATA        = 8'h0C;
  localparam logic [7:0]  REG_STAT        = 8'h10;
  // ==========================================================================
  // field positions
  localparam int          CTRL_KIND_LSB   = 0;
  localparam int          CTRL_MODE256    = 3;
  localparam int          CTRL_START      = 4;
  localparam int          CTRL_WP         = 5;
  localparam int          ADDR_OFF_LSB    = 16;
  localparam int          STAT_BUSY       = 0;
  localparam int          STAT_DONE       = 1;
  localparam int          STAT_EPE        = 2;
  localparam int          STAT_BYTE_LSB   = 8;
  localparam int          PAGE_W          = 10;
  localparam int          OFF_W           = 9;
  localparam int          IDX_W           = 9;
  // ==========================================================================
  // flash command bytes
  localparam logic [7:0]  OP_BLOCK        = 8'h50;
  localparam logic [7:0]  OP_SECTOR       = 8'h7C;
  localparam logic [7:0]  OP_RMW          = 8'h58;
  localparam logic [7:0]  CHIP_B0         = 8'hC7;
  localparam logic [7:0]  CHIP_B1         = 8'h94;
  localparam logic [7:0]  CHIP_B2         = 8'h80;
  localparam logic [7:0]  CHIP_B3         = 8'h9A;
  localparam logic [7:0]  OP_STATUS_DEF   = 8'hD7;
  localparam int          DEV_RDY_BIT     = 7;
  localparam int          DEV_EPE_BIT     = 5;
  localparam logic [8:0]  HDR_BYTES       = 9'h004;
  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    KIND_BLOCK  = 3'b000,
    KIND_SECTOR = 3'b001,
    KIND_CHIP   = 3'b010,
    KIND_RMW    = 3'b011
  } sfe_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW  = 3'b001,
    ST_HIGH = 3'b010,
    ST_GAP  = 3'b011,
    ST_FIN  = 3'b100
  } sfe_state_type;

  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } sfe_bus_req_type;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } sfe_pins_type;
endpackage

// >>> rtl/sfe_sequencer.sv
/*
  host-side sequencer that issues block erase, sector erase, chip erase and
  read-modify-write to a serial flash, then polls its status until ready.
  assumes spi mode 0, the flash driving its output on the falling clock edge,
  and software that writes the registers only while the sequencer is idle.
*/
// Added by the designer: strobed register access and the address map.
// Notes on behaviour
// - block erase 264: 50h, page bits 9..3
// - block erase 256: linear bits 17..11 only
// - sector 0a/0b erase 264: 7Ch, page 9..3
// - sectors 1-7 in 264: page 9..7 only
// - sector erase 256: linear 17..11 or 17..15
// - chip erase is exactly C7h 94h 80h 9Ah
// - nothing follows chip bytes; deselect starts it
// - modify 264: 58h, ten page, nine offset bits
// - modify 256: page 17..8, offset 7..0
// - deselect only on whole byte boundaries
module sfe_sequencer #(
  parameter int          DATA_DEPTH  = 264,
  parameter int          SCK_HALF    = 4,
  parameter logic [7:0]  OP_STATUS   = sfe_pkg::OP_STATUS_DEF
) (
  input  wire logic                            CLK_SYS_IN,
  input  wire logic                            RST_N_IN,
  input  wire sfe_pkg::sfe_bus_req_type        BUS_IN,
  output logic [sfe_pkg::REG_DATA_W-1:0]       RDATA_OUT,
  output sfe_pkg::sfe_pins_type                PINS_OUT,
  input  wire logic                            SO_IN
);
  import sfe_pkg::*;

  // ==========================================================================
  // registers and state
  sfe_kind_type          kind_q;
  logic                  mode256_q;
  logic                  wp_q;
  logic [PAGE_W-1:0]     page_q;
  logic [OFF_W-1:0]      off_q;
  logic [IDX_W-1:0]      count_q;
  logic [IDX_W-1:0]      wptr_q;
  logic [7:0]            data_q [DATA_DEPTH];
  sfe_state_type         state_q;
  logic [7:0]            tmr_q;
  logic [2:0]            bit_q;
  logic [IDX_W-1:0]      idx_q;
  logic [7:0]            shift_q;
  logic                  poll_q;
  logic                  done_q;
  logic [7:0]            stat_q;
  logic                  so_meta_q;
  logic                  so_q;
  sfe_pins_type          pins_q;
  logic [REG_DATA_W-1:0] rdata_q;

  logic                  busy;
  logic                  start_ok;
  logic                  half_end;
  logic [IDX_W-1:0]      total;
  logic [IDX_W-1:0]      nxt_idx;
  logic [7:0]            byte_first;
  logic [7:0]            byte_nxt;
  logic [7:0]            shift_n;
  logic [23:0]           addr_word;

  // ==========================================================================
  // address layout for each command and page-size mode
  function automatic logic [23:0] make_addr(input sfe_kind_type k, input logic m256,
                                            input logic [PAGE_W-1:0] pg_in,
                                            input logic [OFF_W-1:0] of_in);
    logic [PAGE_W-1:0] pg;
    logic [OFF_W-1:0]  of;
    pg = pg_in;
    of = of_in;
    unique case (k)
      KIND_BLOCK: begin
        pg[2:0] = 3'h0;
        of      = '0;
      end
      KIND_SECTOR: begin
        if (pg_in[9:7] == 3'h0) begin
          pg[2:0] = 3'h0;
        end else begin
          pg[6:0] = 7'h00;
        end
        of = '0;
      end
      default: begin
      end
    endcase
    if (m256) begin
      make_addr = {6'h00, pg, of[7:0]};
    end else begin
      make_addr = {5'h00, pg, of};
    end
  endfunction

  // byte sent at position i of the command frame
  function automatic logic [7:0] frame_byte(input sfe_kind_type k, input logic [IDX_W-1:0] i,
                                            input logic [23:0] a, input logic [7:0] d);
    frame_byte = d;
    if (k == KIND_CHIP) begin
      unique case (i[1:0])
        2'h0: frame_byte = CHIP_B0;
        2'h1: frame_byte = CHIP_B1;
        2'h2: frame_byte = CHIP_B2;
        2'h3: frame_byte = CHIP_B3;
      endcase
    end else if (i == 9'h000) begin
      frame_byte = (k == KIND_BLOCK) ? OP_BLOCK : (k == KIND_SECTOR) ? OP_SECTOR : OP_RMW;
    end else if (i == 9'h001) begin
      frame_byte = a[23:16];
    end else if (i == 9'h002) begin
      frame_byte = a[15:8];
    end else if (i == 9'h003) begin
      frame_byte = a[7:0];
    end
  endfunction

  // ==========================================================================
  // combinational helpers
  assign busy      = (state_q != ST_IDLE);
  assign half_end  = (tmr_q == 8'(SCK_HALF - 1));
  assign start_ok  = BUS_IN.wr && (BUS_IN.addr == REG_CTRL) && !busy &&
                     BUS_IN.wdata[CTRL_START] && (BUS_IN.wdata[2] == 1'b0);
  assign total     = (kind_q == KIND_RMW) ? HDR_BYTES + count_q : HDR_BYTES;
  assign nxt_idx   = idx_q + 9'h001;
  assign addr_word = make_addr(kind_q, mode256_q, page_q, off_q);
  assign shift_n   = {shift_q[6:0], so_q};
  assign byte_nxt  = frame_byte(kind_q, nxt_idx, addr_word,
                                data_q[IDX_W'(nxt_idx - HDR_BYTES) % DATA_DEPTH]);
  assign byte_first = frame_byte(sfe_kind_type'(BUS_IN.wdata[2:0]), 9'h000,
                                 make_addr(sfe_kind_type'(BUS_IN.wdata[2:0]),
                                           BUS_IN.wdata[CTRL_MODE256], page_q, off_q),
                                 8'h00);

  // ==========================================================================
  // input synchroniser: the flash output is asynchronous to our clock
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      so_meta_q <= 1'b0;
      so_q      <= 1'b0;
    end else begin
      so_meta_q <= SO_IN;
      so_q      <= so_meta_q;
    end
  end

  // ==========================================================================
  // configuration registers; frozen while a command runs
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      kind_q    <= KIND_BLOCK;
      mode256_q <= 1'b0;
      wp_q      <= 1'b0;
      page_q    <= '0;
      off_q     <= '0;
      count_q   <= '0;
    end else if (BUS_IN.wr && !busy) begin
      if (BUS_IN.addr == REG_CTRL) begin
        if (BUS_IN.wdata[2] == 1'b0) begin
          kind_q <= sfe_kind_type'(BUS_IN.wdata[2:0]);
        end
        mode256_q <= BUS_IN.wdata[CTRL_MODE256];
        wp_q      <= BUS_IN.wdata[CTRL_WP];
      end else if (BUS_IN.addr == REG_ADDR) begin
        page_q <= BUS_IN.wdata[PAGE_W-1:0];
        off_q  <= BUS_IN.wdata[ADDR_OFF_LSB +: OFF_W];
      end else if (BUS_IN.addr == REG_COUNT) begin
        count_q <= (BUS_IN.wdata[IDX_W-1:0] > IDX_W'(DATA_DEPTH)) ?
                   IDX_W'(DATA_DEPTH) : BUS_IN.wdata[IDX_W-1:0];
      end
    end
  end

  // ==========================================================================
  // data bytes for read-modify-write; count write rewinds the fill pointer
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wptr_q <= '0;
    end else if (BUS_IN.wr && !busy && BUS_IN.addr == REG_COUNT) begin
      wptr_q <= '0;
    end else if (BUS_IN.wr && !busy && BUS_IN.addr == REG_DATA &&
                 wptr_q < IDX_W'(DATA_DEPTH)) begin
      wptr_q <= wptr_q + 9'h001;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (BUS_IN.wr && !busy && BUS_IN.addr == REG_DATA && wptr_q < IDX_W'(DATA_DEPTH)) begin
      data_q[wptr_q] <= BUS_IN.wdata[7:0];
    end
  end

  // ==========================================================================
  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (BUS_IN.rd) begin
        unique case (BUS_IN.addr)
          REG_CTRL:  rdata_q <= {26'h0, wp_q, 1'b0, mode256_q, kind_q};
          REG_ADDR:  rdata_q <= {7'h00, off_q, 6'h00, page_q};
          REG_COUNT: rdata_q <= {23'h0, count_q};
          REG_STAT:  rdata_q <= {16'h0000, stat_q, 5'h00, stat_q[DEV_EPE_BIT], done_q, busy};
          default:   rdata_q <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // serial engine: command frame, deselect gap, then status polling
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      tmr_q   <= '0;
      bit_q   <= '0;
      idx_q   <= '0;
      shift_q <= '0;
      poll_q  <= 1'b0;
      done_q  <= 1'b0;
      stat_q  <= '0;
      pins_q  <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
    end else begin
      pins_q.wp_n <= !wp_q;  // flash itself defers protection
      unique case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            done_q      <= 1'b0;
            idx_q       <= '0;
            bit_q       <= '0;
            tmr_q       <= '0;
            poll_q      <= 1'b0;
            shift_q     <= byte_first;
            pins_q.si   <= byte_first[7];
            pins_q.cs_n <= 1'b0;
            state_q     <= ST_LOW;
          end
        end
        ST_LOW: begin
          tmr_q <= half_end ? 8'h00 : tmr_q + 8'h01;
          if (half_end) begin
            pins_q.sck <= 1'b1;
            state_q    <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          tmr_q <= half_end ? 8'h00 : tmr_q + 8'h01;
          if (half_end) begin
            pins_q.sck <= 1'b0;
            bit_q      <= bit_q + 3'h1;
            state_q    <= ST_LOW;
            shift_q    <= shift_n;
            pins_q.si  <= shift_n[7];
            if (bit_q == 3'h7) begin
              if (!poll_q && nxt_idx == total) begin
                pins_q.cs_n <= 1'b1;  // deselect only after the last whole byte
                state_q     <= ST_GAP;
              end else if (!poll_q) begin
                idx_q     <= nxt_idx;
                shift_q   <= byte_nxt;
                pins_q.si <= byte_nxt[7];
              end else begin
                idx_q     <= 9'h001;
                shift_q   <= 8'h00;
                pins_q.si <= 1'b0;
                if (idx_q != 9'h000) begin
                  stat_q <= shift_n;
                  if (shift_n[DEV_RDY_BIT]) begin
                    pins_q.cs_n <= 1'b1;  // ready seen, command complete
                    state_q     <= ST_FIN;
                  end
                end
              end
            end
          end
        end
        ST_GAP: begin
          tmr_q <= half_end ? 8'h00 : tmr_q + 8'h01;
          if (half_end) begin
            pins_q.cs_n <= 1'b0;
            poll_q      <= 1'b1;
            idx_q       <= '0;
            shift_q     <= OP_STATUS;
            pins_q.si   <= OP_STATUS[7];
            state_q     <= ST_LOW;
          end
        end
        ST_FIN: begin
          tmr_q   <= half_end ? 8'h00 : tmr_q + 8'h01;
          if (half_end) begin
            done_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign PINS_OUT  = pins_q;
  assign RDATA_OUT = rdata_q;

  // ==========================================================================
  // checks
  sequence s_frame_last_bit;
    state_q == ST_HIGH && half_end && bit_q == 3'h7 && !poll_q && nxt_idx == total;
  endsequence

  sequence s_deselect_gap;
    pins_q.cs_n && state_q == ST_GAP;
  endsequence

  a_frame_whole_end: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $rose(pins_q.cs_n) && !poll_q |-> bit_q == 3'h0 && idx_q == total - 9'h001)
    else $error("frame ended mid-byte or early");

  a_frame_then_gap: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    s_frame_last_bit |=> s_deselect_gap)
    else $error("frame end did not deselect");

  a_chip_first_byte: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $fell(pins_q.cs_n) && !poll_q && kind_q == KIND_CHIP |-> shift_q == CHIP_B0)
    else $error("chip erase opcode wrong");

  a_block_dummy_bits: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    busy && kind_q == KIND_BLOCK |-> addr_word[10:0] == 11'h000 && (mode256_q || !addr_word[11]))
    else $error("block erase dummy bits not zero");

  a_sector_high_sel: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    busy && kind_q == KIND_SECTOR && page_q[9:7] != 3'h0 && !mode256_q
    |-> addr_word[15:0] == 16'h0000)
    else $error("sector 1-7 address carries low bits");

  a_done_when_ready: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $rose(done_q) |-> stat_q[DEV_RDY_BIT] && pins_q.cs_n)
    else $error("done without ready status");

  a_poll_after_gap: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    s_deselect_gap ##1 (state_q != ST_GAP) |-> poll_q && !pins_q.cs_n && state_q == ST_LOW)
    else $error("no status poll after command");

  a_no_sck_deselected: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    pins_q.cs_n |-> !pins_q.sck)
    else $error("serial clock toggled while deselected");

  a_rmw_byte_count: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    $rose(pins_q.cs_n) && !poll_q && kind_q == KIND_RMW |-> idx_q == HDR_BYTES + count_q - 9'h001)
    else $error("modify frame length wrong");
endmodule

// >>> tb/sfe_flash_model.sv
/*
  behavioural serial flash on the far side of the sequencer: collects frames,
  decodes erase and modify commands and answers status polling.
  assumes spi mode 0 with the host making the serial clock.
*/
module sfe_flash_model
  import sfe_pkg::*;
#(
  parameter int BUSY_NS = 4000
) (
  input  wire sfe_pkg::sfe_pins_type PINS_IN,
  input  wire logic                  MODE256_IN,
  input  wire logic                  FAIL_IN,
  output logic                       SO_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cur_q[$];
  logic [7:0]  last_q[$];
  logic [7:0]  shift_q;
  logic [7:0]  stat_q;
  logic [23:0] addr_q;
  logic [9:0]  page_q;
  logic        busy_q = 1'b0;
  logic        epe_q = 1'b0;
  logic        prot_q = 1'b0;
  logic        rewrite_q = 1'b0;
  logic        spared_q = 1'b0;
  logic [7:0]  erased_q = 8'h00;
  int          bits_q = 0;
  int          frames_q = 0;
  int          bad_q = 0;
  int          blk_q = 0;
  int          sec_q = 0;
  initial SO_OUT = 1'b0;
  // ==========================================================================
  // frame capture
  always @(negedge PINS_IN.cs_n) begin
    bits_q = 0;
    cur_q.delete();
  end
  always @(posedge PINS_IN.sck) begin
    if (!PINS_IN.cs_n) begin
      shift_q = {shift_q[6:0], PINS_IN.si};
      bits_q++;
      if (bits_q % 8 == 0) begin
        cur_q.push_back(shift_q);
      end
      if (bits_q == 8 && busy_q && shift_q != OP_STATUS_DEF) begin
        bad_q++;
      end
    end
  end
  // status shifts out on the fall so the host can take it on the next fall, as it ends the high phase
  always @(negedge PINS_IN.sck) begin
    if (!PINS_IN.cs_n && cur_q.size() > 0 && cur_q[0] == OP_STATUS_DEF) begin
      if (bits_q % 8 == 0) begin
        stat_q = {~busy_q, 1'b0, epe_q, 5'h00};
      end
      SO_OUT = stat_q[7 - bits_q % 8];
    end
  end
  // ==========================================================================
  // deselect starts the self-timed work
  always @(posedge PINS_IN.cs_n) begin
    SO_OUT = ~SO_OUT;  // released line must not keep its last level
    if (cur_q.size() > 0 && cur_q[0] != OP_STATUS_DEF) begin
      if (bits_q % 8 != 0 || bits_q < 32) begin
        bad_q++;
      end else begin
        last_q = cur_q;
        frames_q++;
        addr_q = {cur_q[1], cur_q[2], cur_q[3]};
        page_q = MODE256_IN ? addr_q[17:8] : addr_q[18:9];
        blk_q = page_q[9:3];
        sec_q = (page_q[9:7] == 3'h0) ? page_q[3] : page_q[9:7] + 1;
        rewrite_q = (cur_q[0] == OP_RMW && cur_q.size() == 4);
        erased_q = (cur_q[0] == OP_RMW) ? 8'h00 : 8'hFF;
        if (cur_q[0] == CHIP_B0) spared_q = prot_q;
        busy_q = 1'b1;
        epe_q = FAIL_IN;
        #(BUSY_NS);
        busy_q = 1'b0;
      end
    end
  end
  always @(PINS_IN.wp_n) begin
    wait (!busy_q);
    prot_q = !PINS_IN.wp_n;
  end
endmodule

// >>> tb/sfe_sequencer_test.sv
/*
  self-checking bench for the flash sequencer: random erase and modify jobs.
  assumes the flash model answers status polls and records each frame.
*/
module sfe_sequencer_test
  import sfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys;
  logic            rst_n;
  sfe_bus_req_type bus;
  logic [31:0]     rdata;
  sfe_pins_type    pins;
  logic            so;
  logic            mode256;
  logic            fail;
  int              error_cnt;
  int              checks;
  logic [31:0]     rd_val;
  logic [7:0]      exp_q[$];

  sfe_sequencer #(.DATA_DEPTH(264), .SCK_HALF(4), .OP_STATUS(OP_STATUS_DEF)) u_sfe_sequencer (
    .CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .BUS_IN(bus), .RDATA_OUT(rdata),
    .PINS_OUT(pins), .SO_IN(so));
  sfe_flash_model #(.BUSY_NS(4000)) u_sfe_flash_model (
    .PINS_IN(pins), .MODE256_IN(mode256), .FAIL_IN(fail), .SO_OUT(so));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic reg_rd(input logic [7:0] a);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    rd_val = rdata;
    @(posedge clk_sys);
  endtask
  // polling is bounded; a hang ends the run as a mismatch
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      reg_rd(REG_STAT);
      n++;
    end while (rd_val[STAT_BUSY] !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // ==========================================================================
  // one job: k 0 block, 1 low sector, 2 high sector, 3 chip, 4 modify, 5 rewrite
  task automatic run_op(input int k, input logic m);
    logic [9:0]  pg;
    logic [9:0]  ep;
    logic [8:0]  off;
    logic [8:0]  eo;
    logic [23:0] addr;
    logic [7:0]  b;
    logic        wp;
    logic        fl;
    int          kind;
    int          n;
    int          f0;
    pg = 10'($urandom);
    off = m ? 9'($urandom % 256) : 9'($urandom % 264);
    wp = 1'($urandom);
    fl = 1'($urandom);
    fail <= fl;
    mode256 <= m;
    if (k == 1) pg[9:7] = 3'h0;
    if (k == 2 && pg[9:7] == 3'h0) pg[9] = 1'b1;
    kind = (k == 0) ? 0 : (k < 3) ? 1 : (k == 3) ? 2 : 3;
    n = (k == 4) ? 1 + $urandom % 6 : 0;
    ep = pg;
    eo = off;
    if (kind < 2) begin
      eo = 9'h000;
      ep = (kind == 0 || pg[9:7] == 3'h0) ? {pg[9:3], 3'h0} : {pg[9:7], 7'h00};
    end
    addr = m ? {6'h00, ep, eo[7:0]} : {5'h00, ep, eo};
    b = (kind == 0) ? OP_BLOCK : (kind == 1) ? OP_SECTOR : OP_RMW;
    exp_q = '{b, addr[23:16], addr[15:8], addr[7:0]};
    if (kind == 2) exp_q = '{CHIP_B0, CHIP_B1, CHIP_B2, CHIP_B3};
    f0 = u_sfe_flash_model.frames_q;
    reg_wr(REG_ADDR, {7'h00, off, 6'h00, pg});
    reg_rd(REG_ADDR);
    chk(rd_val, {7'h00, off, 6'h00, pg});
    reg_wr(REG_COUNT, 32'(n));
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      reg_wr(REG_DATA, 32'(b));
    end
    reg_wr(REG_CTRL, 32'({wp, 1'b1, m, 3'(kind)}));
    reg_rd(REG_STAT);
    chk(rd_val[STAT_BUSY], 1'b1);
    chk(pins.wp_n, !wp);
    wait_done();
    chk(rd_val, {16'h0000, 2'h2, fl, 5'h00, 5'h00, fl, 2'h2});
    chk(u_sfe_flash_model.prot_q, wp);
    reg_rd(REG_CTRL);
    chk(rd_val, {26'h0, wp, 1'b0, m, 3'(kind)});
    chk(u_sfe_flash_model.frames_q, f0 + 1);
    chk(u_sfe_flash_model.last_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      chk(u_sfe_flash_model.last_q[i], exp_q[i]);
    end
    chk(u_sfe_flash_model.bad_q, 0);
    if (kind == 0) chk(u_sfe_flash_model.blk_q, pg[9:3]);
    if (kind == 1) chk(u_sfe_flash_model.sec_q, pg[9:7] == 0 ? pg[3] : pg[9:7] + 1);
    if (kind == 3) chk(u_sfe_flash_model.rewrite_q, n == 0);
    if (kind == 2) chk(u_sfe_flash_model.spared_q, wp);
    chk(u_sfe_flash_model.erased_q, (kind == 3) ? 8'h00 : 8'hFF);
    $display("test %0d mode %0d done", k, m);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    bus = '0;
    mode256 = 1'b0;
    fail = 1'b0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'h0a84_db10));
    repeat (4) @(posedge clk_sys);
    chk(pins, 4'h9);
    chk(rdata, 32'h0000_0000);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    reg_rd(8'h14);
    chk(rd_val, 32'h0000_0000);
    reg_wr(REG_CTRL, 32'h0000_0014);
    reg_rd(REG_STAT);
    chk(rd_val[STAT_BUSY], 1'b0);
    chk(pins.cs_n, 1'b1);
    reg_wr(REG_COUNT, 32'h0000_01FF);
    reg_rd(REG_COUNT);
    chk(rd_val, 32'h0000_0108);
    $display("test refused start done");
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 6; k++) begin
        run_op(k, m[0]);
      end
    end
    give_verdict();
  end
endmodule
